/* File: rtl/card_host_cfg.svh */
// Timing, width and idle-level constants for the card host controller.
`ifndef CARD_HOST_CFG_SVH
`define CARD_HOST_CFG_SVH
`define CARD_CLK_NS 20
`define CARD_SETUP_NS 30
`define CARD_STROBE_NS 165
`define CARD_HOLD_NS 20
`define CARD_FIFO_DEPTH 16
`define CARD_DATA_W 16
`define CARD_ADDR_W 11
`define CARD_TASK_ADDR_W 3
`define CARD_ODD_LSB 8
`define CARD_IDLE_ADDR 11'h000
`define CARD_IDLE_DATA 16'h0000
`endif

/* File: rtl/card_host_pkg.sv */
// Types shared by the card host controller, the card model, the checker and the bench.
package card_host_pkg;
	typedef enum logic [1:0] {MODE_MEMORY, MODE_IO, MODE_NATIVE} mode_t;
	typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_DMA_READ, OP_DMA_WRITE} op_t;
	typedef enum logic [1:0] {
		WIDTH_EVEN_BYTE, WIDTH_ODD_BYTE_LOW, WIDTH_ODD_BYTE_HIGH, WIDTH_WORD
	} width_t;
	typedef struct packed {
		op_t op;
		width_t width;
		logic attribute;
		logic auxSelect;
		logic [10:0] addr;
		logic [15:0] data;
	} cmd_t;
	typedef struct packed {
		logic [15:0] data;
		logic acknowledged;
	} rsp_t;
	typedef struct packed {
		logic [10:0] addr;
		logic evenLaneCardEnableN;
		logic oddLaneCardEnableN;
		logic attrSelectN;
		logic outputEnableN;
		logic writeEnableN;
		logic ioReadN;
		logic ioWriteN;
		logic dmaAckN;
		logic [15:0] dataOut;
		logic dataOe;
	} pins_t;
endpackage : card_host_pkg

/* File: rtl/card_host_bus_select_and_dma.sv */
// Host controller that drives a flash card over its parallel pins, with FIFO.
// Contract
// - Native mode: first select reaches task file, second the aux registers.
// - Even byte on low lanes, odd byte on high lanes, or on low lanes for 8 bit hosts.
// - Native register accesses are bytes on D7-D0; data transfers 16 bits.
// - Device raises DMA request; host picks direction by read/write strobe.
// - DMA request held until acknowledge, raised again for more data.
// - I/O and native reads: read strobe low while card drives data.
// - Attribute select high for common, low for attribute and I/O cycles.
`timescale 1ns/1ps
`include "card_host_cfg.svh"

module word_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = `CARD_FIFO_DEPTH
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic reset_n,
	// Filling side.
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Draining side.
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int PW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wrPtr;
		logic [PW-1:0] rdPtr;
		logic [PW:0] count;
		logic valid;
		logic [WIDTH-1:0] head;
	} fifo_state_t;
	fifo_state_t state_reg, state_next;
	logic doPush, doPop;

	assign inReady = state_reg.count != (PW+1)'(DEPTH);
	assign outValid = state_reg.valid;
	assign outData = state_reg.head;
	assign doPush = inValid && inReady;
	assign doPop = outValid && outReady;

	always_comb begin
		state_next = state_reg;
		if (doPush) begin
			state_next.mem[state_reg.wrPtr] = inData;
			state_next.wrPtr = state_reg.wrPtr + 1'b1;
		end
		if (doPop) begin
			state_next.rdPtr = state_reg.rdPtr + 1'b1;
		end
		case ({doPush, doPop})
			2'b10: state_next.count = state_reg.count + 1'b1;
			2'b01: state_next.count = state_reg.count - 1'b1;
			default: state_next.count = state_reg.count;
		endcase
		// Registering the head keeps the draining outputs straight from flops.
		state_next.valid = state_next.count != '0;
		state_next.head = state_next.mem[state_next.rdPtr];
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end
endmodule : word_fifo

module card_host_bus_select_and_dma #(
	parameter int FIFO_DEPTH = `CARD_FIFO_DEPTH
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic reset_n,
	// Straps sampled once after reset.
	input wire card_host_pkg::mode_t modeStrap,
	input wire logic roleMaster,
	// Command port.
	input wire logic cmdValid,
	output logic cmdReady,
	input wire card_host_pkg::cmd_t cmd,
	// Read answers, buffered.
	output logic rspValid,
	input wire logic rspReady,
	output card_host_pkg::rsp_t rsp,
	// Card pins.
	output card_host_pkg::pins_t pins,
	input wire logic [15:0] dataIn,
	input wire logic inputAcknowledgeN,
	input wire logic dmaRequest,
	output logic roleSelectStrapOut,
	output logic roleSelectStrapOe
);
	import card_host_pkg::*;

	localparam logic [7:0] SETUP_CYC =
		8'((`CARD_SETUP_NS + `CARD_CLK_NS - 1) / `CARD_CLK_NS);
	localparam logic [7:0] STROBE_CYC =
		8'((`CARD_STROBE_NS + `CARD_CLK_NS - 1) / `CARD_CLK_NS);
	localparam logic [7:0] HOLD_CYC =
		8'((`CARD_HOLD_NS + `CARD_CLK_NS - 1) / `CARD_CLK_NS);

	typedef enum logic [2:0] {
		PH_IDLE, PH_DMA_WAIT, PH_SETUP, PH_STROBE, PH_HOLD
	} phase_t;

	typedef struct packed {
		phase_t phase;
		logic [7:0] cnt;
		logic modeKnown;
		mode_t mode;
		cmd_t cmd;
		pins_t pins;
		logic cmdReady;
		logic roleOe;
		logic ackSeen;
		logic push;
		rsp_t pushData;
	} host_state_t;

	host_state_t state_reg, state_next;
	logic fifoInReady;

	localparam pins_t IDLE_PINS = '{
		addr: `CARD_IDLE_ADDR, evenLaneCardEnableN: 1'b1,
		oddLaneCardEnableN: 1'b1, attrSelectN: 1'b1, outputEnableN: 1'b1,
		writeEnableN: 1'b1, ioReadN: 1'b1, ioWriteN: 1'b1, dmaAckN: 1'b1,
		dataOut: `CARD_IDLE_DATA, dataOe: 1'b0};

	// The odd byte reaches the high lanes only through the odd-lane enable.
	function automatic logic highLanes(input width_t w);
		highLanes = (w == WIDTH_ODD_BYTE_HIGH);
	endfunction : highLanes

	function automatic logic isDma(input mode_t m, input op_t o);
		isDma = (m == MODE_NATIVE) && (o == OP_DMA_READ || o == OP_DMA_WRITE);
	endfunction : isDma

	function automatic logic isWrite(input op_t o);
		isWrite = (o == OP_WRITE) || (o == OP_DMA_WRITE);
	endfunction : isWrite

	function automatic pins_t selectPins(input mode_t m, input cmd_t c);
		pins_t p;
		p = IDLE_PINS;
		if (m == MODE_NATIVE) begin
			p.addr = {8'h00, c.addr[`CARD_TASK_ADDR_W-1:0]};
			if (!isDma(m, c.op)) begin
				p.evenLaneCardEnableN = c.auxSelect;
				p.oddLaneCardEnableN = !c.auxSelect;
			end
			p.dataOut = isDma(m, c.op) ? c.data :
				{8'h00, c.data[7:0]};
		end else begin
			p.addr = {c.addr[10:1], 1'b0};
			case (c.width)
				WIDTH_EVEN_BYTE: begin
					p.evenLaneCardEnableN = 1'b0;
					p.dataOut = {8'h00, c.data[7:0]};
				end
				WIDTH_ODD_BYTE_LOW: begin
					// An 8 bit host gets the odd byte on the low lanes.
					p.evenLaneCardEnableN = 1'b0;
					p.addr[0] = 1'b1;
					p.dataOut = {8'h00, c.data[7:0]};
				end
				WIDTH_ODD_BYTE_HIGH: begin
					p.oddLaneCardEnableN = 1'b0;
					p.addr[0] = 1'b1;
					p.dataOut = {c.data[7:0], 8'h00};
				end
				default: begin
					p.evenLaneCardEnableN = 1'b0;
					p.oddLaneCardEnableN = 1'b0;
					p.dataOut = c.data;
				end
			endcase
			// Common memory high, attribute memory and I/O cycles low.
			p.attrSelectN = (m == MODE_MEMORY) ? !c.attribute : 1'b0;
		end
		p.dataOe = isWrite(c.op);
		selectPins = p;
	endfunction : selectPins

	function automatic logic [15:0] pickData(input mode_t m, input cmd_t c,
		input logic [15:0] d);
		if (isDma(m, c.op) || (m != MODE_NATIVE && c.width == WIDTH_WORD)) begin
			pickData = d;
		end else if (m != MODE_NATIVE && highLanes(c.width)) begin
			pickData = {8'h00, d[15:`CARD_ODD_LSB]};
		end else begin
			pickData = {8'h00, d[7:0]};
		end
	endfunction : pickData

	always_comb begin
		state_next = state_reg;
		state_next.push = 1'b0;
		case (state_reg.phase)
			PH_IDLE: begin
				if (!state_reg.modeKnown) begin
					state_next.modeKnown = 1'b1;
					state_next.mode = modeStrap;
					// Card modes ground the strap rather than leave it floating.
					state_next.roleOe = (modeStrap == MODE_NATIVE) ?
						roleMaster : 1'b1;
				end else if (cmdValid && state_reg.cmdReady) begin
					state_next.cmd = cmd;
					state_next.cmdReady = 1'b0;
					state_next.ackSeen = 1'b0;
					state_next.pins = selectPins(state_reg.mode, cmd);
					state_next.cnt = SETUP_CYC;
					if (isDma(state_reg.mode, cmd.op)) begin
						state_next.phase = PH_DMA_WAIT;
					end else begin
						state_next.phase = PH_SETUP;
					end
				end else begin
					// One read in flight at most, so a free slot means no overrun.
					state_next.cmdReady = fifoInReady;
				end
			end
			PH_DMA_WAIT: begin
				if (dmaRequest) begin
					state_next.pins.dmaAckN = 1'b0;
					state_next.phase = PH_SETUP;
				end
			end
			PH_SETUP: begin
				if (state_reg.cnt <= 8'h01) begin
					state_next.cnt = STROBE_CYC;
					state_next.phase = PH_STROBE;
					if (state_reg.mode == MODE_MEMORY) begin
						// Memory cycles use output and write enables only.
						state_next.pins.outputEnableN =
							isWrite(state_reg.cmd.op);
						state_next.pins.writeEnableN = !isWrite(state_reg.cmd.op);
					end else begin
						state_next.pins.ioReadN = isWrite(state_reg.cmd.op);
						state_next.pins.ioWriteN = !isWrite(state_reg.cmd.op);
					end
				end else begin
					state_next.cnt = state_reg.cnt - 8'h01;
				end
			end
			PH_STROBE: begin
				if (state_reg.mode == MODE_IO && !inputAcknowledgeN) begin
					state_next.ackSeen = 1'b1;
				end
				if (state_reg.cnt <= 8'h01) begin
					// Data stays driven past the rising write edge for hold.
					state_next.pins.outputEnableN = 1'b1;
					state_next.pins.writeEnableN = 1'b1;
					state_next.pins.ioReadN = 1'b1;
					state_next.pins.ioWriteN = 1'b1;
					state_next.cnt = HOLD_CYC;
					state_next.phase = PH_HOLD;
					if (!isWrite(state_reg.cmd.op)) begin
						state_next.push = 1'b1;
						state_next.pushData.data =
							pickData(state_reg.mode, state_reg.cmd, dataIn);
						state_next.pushData.acknowledged =
							state_reg.ackSeen || (state_reg.mode == MODE_IO &&
							!inputAcknowledgeN);
					end
				end else begin
					state_next.cnt = state_reg.cnt - 8'h01;
				end
			end
			PH_HOLD: begin
				if (state_reg.cnt <= 8'h01) begin
					// Releasing the acknowledge lets the card request again.
					state_next.pins = IDLE_PINS;
					state_next.phase = PH_IDLE;
				end else begin
					state_next.cnt = state_reg.cnt - 8'h01;
				end
			end
			default: begin
				state_next.pins = IDLE_PINS;
				state_next.phase = PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= '{phase: PH_IDLE, cnt: 8'h00, modeKnown: 1'b0,
				mode: MODE_MEMORY, cmd: '0, pins: IDLE_PINS, cmdReady: 1'b0,
				roleOe: 1'b1, ackSeen: 1'b0, push: 1'b0, pushData: '0};
		end else begin
			state_reg <= state_next;
		end
	end

	word_fifo #(
		.WIDTH($bits(rsp_t)),
		.DEPTH(FIFO_DEPTH)
	) readFifo (
		.clock(clock),
		.reset_n(reset_n),
		.inValid(state_reg.push),
		.inReady(fifoInReady),
		.inData(state_reg.pushData),
		.outValid(rspValid),
		.outReady(rspReady),
		.outData(rsp)
	);

	assign cmdReady = state_reg.cmdReady;
	assign pins = state_reg.pins;
	assign roleSelectStrapOut = 1'b0;
	assign roleSelectStrapOe = state_reg.roleOe;
endmodule : card_host_bus_select_and_dma

/* File: verification/card_model.sv */
// Behavioural flash card that answers the host controller's pins.
`timescale 1ns/1ps
module card_model (
	// Clock, strap and host pins.
	input wire logic clock,
	input wire card_host_pkg::mode_t modeStrap,
	input wire card_host_pkg::pins_t pins,
	input wire logic dmaGo,
	// Card outputs.
	output logic [15:0] dataIn,
	output logic inputAcknowledgeN,
	output logic dmaRequest
);
	import card_host_pkg::*;
	logic [7:0] m [0:2047];
	logic [7:0] t [0:15];
	logic [15:0] dw, v, w;
	logic [10:0] e, o;
	logic [3:0] r;
	logic mem, en, odd, rdN, wrN, wrPrev;
	initial begin
		dataIn = 16'h0000;
		inputAcknowledgeN = 1'b1;
		dmaRequest = 1'b0;
		foreach (m[j]) m[j] = 8'h00;
		foreach (t[j]) t[j] = 8'h00;
	end
	always_comb begin
		mem = modeStrap == MODE_MEMORY;
		e = {pins.addr[10:1], 1'b0};
		o = e | 11'h001;
		en = !pins.evenLaneCardEnableN;
		odd = !pins.oddLaneCardEnableN;
		r = {odd, pins.addr[2:0]};
		rdN = mem ? pins.outputEnableN : pins.ioReadN;
		wrN = mem ? pins.writeEnableN : pins.ioWriteN;
		w = pins.dataOut;
		if (!pins.dmaAckN)
			v = dw;
		else if (modeStrap == MODE_NATIVE)
			v = {8'h00, t[r]};
		else if (en && odd)
			v = {m[o], m[e]};
		else if (odd)
			v = {m[o], 8'h00};
		else
			v = {8'h00, m[pins.addr]};
	end
	always @(posedge clock) begin
		wrPrev <= wrN;
		if (wrN && !wrPrev) begin
			if (!pins.dmaAckN)
				dw <= w;
			else if (modeStrap == MODE_NATIVE)
				t[r] <= w[7:0];
			else if (en && odd) begin
				m[e] <= w[7:0];
				m[o] <= w[15:8];
			end else if (odd)
				m[o] <= w[15:8];
			else if (en)
				m[pins.addr] <= w[7:0];
		end
		// No pull on the lanes, so released lanes toggle rather than hold.
		if ((en || odd || !pins.dmaAckN) && !rdN)
			dataIn <= v;
		else
			dataIn <= ~dataIn;
		inputAcknowledgeN <= !(modeStrap == MODE_IO && (en || odd)
			&& !pins.ioReadN);
		if (dmaRequest)
			dmaRequest <= pins.dmaAckN;
		else
			dmaRequest <= dmaGo && pins.dmaAckN
				&& modeStrap == MODE_NATIVE;
	end
endmodule : card_model

/* File: verification/card_host_assertions.sv */
// Port checks for the card host controller.
`timescale 1ns/1ps
module card_host_checker (
	// Clock, reset and straps.
	input wire logic clock,
	input wire logic reset_n,
	input wire card_host_pkg::mode_t modeStrap,
	input wire logic roleMaster,
	input wire logic cmdReady,
	// Card side.
	input wire card_host_pkg::pins_t pins,
	input wire logic dmaRequest,
	input wire logic roleSelectStrapOut,
	input wire logic roleSelectStrapOe
);
	import card_host_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	logic nat;
	assign nat = modeStrap == MODE_NATIVE;
	property p_memNoIo;
		modeStrap == MODE_MEMORY |-> pins.ioReadN && pins.ioWriteN;
	endproperty
	a_memNoIo: assert property (p_memNoIo) else $error("io strobe");
	property p_role;
		cmdReady && nat |-> roleSelectStrapOe == roleMaster
			&& !roleSelectStrapOut;
	endproperty
	a_role: assert property (p_role) else $error("role strap");
	property p_addr;
		nat |-> pins.addr[10:3] == 8'h00;
	endproperty
	a_addr: assert property (p_addr) else $error("upper addr");
	property p_sel;
		nat |-> pins.evenLaneCardEnableN || pins.oddLaneCardEnableN;
	endproperty
	a_sel: assert property (p_sel) else $error("two selects");
	property p_lane;
		!nat && !pins.oddLaneCardEnableN
			|-> pins.addr[0] == pins.evenLaneCardEnableN;
	endproperty
	a_lane: assert property (p_lane) else $error("lane a0");
	property p_strobe;
		$fell(pins.ioReadN) |=> !pins.ioReadN [*8] ##1 pins.ioReadN;
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe len");
	property p_noFight;
		!pins.ioReadN || !pins.outputEnableN |-> !pins.dataOe;
	endproperty
	a_noFight: assert property (p_noFight) else $error("drive");
	property p_wrEdge;
		$rose(pins.ioWriteN) || $rose(pins.writeEnableN) |-> pins.dataOe;
	endproperty
	a_wrEdge: assert property (p_wrEdge) else $error("wr data");
	property p_dma;
		$fell(pins.dmaAckN) |-> $past(dmaRequest) && nat;
	endproperty
	a_dma: assert property (p_dma) else $error("dma ack");
	property p_ioAttr;
		modeStrap == MODE_IO && !pins.ioReadN |-> !pins.attrSelectN;
	endproperty
	a_ioAttr: assert property (p_ioAttr) else $error("attr sel");
	c_dma: cover property ($fell(pins.dmaAckN));
	c_ioRead: cover property ($fell(pins.ioReadN));
	c_memWrite: cover property ($rose(pins.writeEnableN));
endmodule : card_host_checker
bind card_host_bus_select_and_dma card_host_checker u_check (
	.clock(clock), .reset_n(reset_n), .modeStrap(modeStrap),
	.roleMaster(roleMaster), .cmdReady(cmdReady), .pins(pins),
	.dmaRequest(dmaRequest), .roleSelectStrapOut(roleSelectStrapOut),
	.roleSelectStrapOe(roleSelectStrapOe));

/* File: verification/card_host_bus_select_and_dma_test.sv */
// Self-checking bench for the card host controller.
`timescale 1ns/1ps
module card_host_bus_select_and_dma_test;
	import card_host_pkg::*;
	logic clock, reset_n, cmdValid, cmdReady, rspValid, rspReady;
	logic inputAcknowledgeN, dmaRequest, roleMaster, dmaGo, stall;
	logic [15:0] dataIn, dw;
	logic [31:0] seed, x;
	logic [7:0] m [0:2047];
	logic [7:0] t [0:15];
	mode_t modeStrap;
	cmd_t cmd;
	rsp_t rsp;
	pins_t pins;
	rsp_t expQ[$];
	int fails, num_checks, k;
	card_host_bus_select_and_dma #(.FIFO_DEPTH(16)) DUT (.clock(clock),
		.reset_n(reset_n), .modeStrap(modeStrap), .roleMaster(roleMaster),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .cmd(cmd),
		.rspValid(rspValid), .rspReady(rspReady), .rsp(rsp), .pins(pins),
		.dataIn(dataIn), .inputAcknowledgeN(inputAcknowledgeN),
		.dmaRequest(dmaRequest), .roleSelectStrapOut(),
		.roleSelectStrapOe());
	card_model card (.clock(clock), .modeStrap(modeStrap), .pins(pins),
		.dmaGo(dmaGo), .dataIn(dataIn),
		.inputAcknowledgeN(inputAcknowledgeN), .dmaRequest(dmaRequest));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic check(string name, logic [16:0] exp, logic [16:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic finish_test();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test
	task automatic send(op_t op, width_t w, logic [10:0] a, logic [15:0] d);
		logic [10:0] e;
		logic [10:0] b;
		logic [3:0] r;
		e = {a[10:1], 1'b0};
		b = w == WIDTH_EVEN_BYTE ? e : e + 11'h001;
		r = {a[10], a[2:0]};
		if (modeStrap == MODE_NATIVE)
			case (op)
				OP_WRITE: t[r] = d[7:0];
				OP_READ: expQ.push_back({8'h00, t[r], 1'b0});
				OP_DMA_WRITE: dw = d;
				default: expQ.push_back({dw, 1'b0});
			endcase
		else if (op == OP_READ)
			expQ.push_back({w == WIDTH_WORD ? {m[e + 1], m[e]} :
				{8'h00, m[b]}, modeStrap == MODE_IO});
		else if (w == WIDTH_WORD) begin
			m[e] = d[7:0];
			m[e + 1] = d[15:8];
		end else
			m[b] = d[7:0];
		cmd <= {op, w, x[3], a[10], a, d};
		cmdValid <= 1'b1;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (cmdReady !== 1'b1 && k < 400);
		cmdValid <= 1'b0;
		@(posedge clock);
		if (k >= 400) begin
			fails++;
			finish_test();
		end
	endtask : send
	task automatic drain();
		k = 0;
		while (expQ.size() > 0 && k < 3000) begin
			@(posedge clock);
			k++;
		end
		if (k >= 3000) begin
			fails++;
			finish_test();
		end
	endtask : drain
	always @(posedge clock) begin
		rspReady <= !stall && rnd() % 3 != 0;
		if (!pins.dmaAckN)
			dmaGo <= 1'b0;
		if (rspValid === 1'b1 && rspReady === 1'b1)
			check("rsp", expQ.size() > 0 ? expQ.pop_front() : 'x, rsp);
	end
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial begin
		seed = 48651;
		{reset_n, cmdValid, rspReady, dmaGo, stall, roleMaster} = '0;
		cmd = '0;
		modeStrap = MODE_MEMORY;
		fails = 0;
		num_checks = 0;
		foreach (m[j]) m[j] = 8'h00;
		foreach (t[j]) t[j] = 8'h00;
		for (int md = 0; md < 3; md++) begin
			@(posedge clock);
			x = rnd();
			reset_n <= 1'b0;
			modeStrap <= mode_t'(md);
			roleMaster <= x[7];
			repeat (10) @(posedge clock);
			reset_n <= 1'b1;
			for (int i = 0; i < 40; i++) begin
				x = rnd();
				if (md == 2) begin
					send(OP_WRITE, WIDTH_EVEN_BYTE, x[31:21], x[15:0]);
					send(OP_READ, WIDTH_EVEN_BYTE, x[31:21], x[15:0]);
					send(x[5] || i == 0 ? OP_DMA_WRITE : OP_DMA_READ,
						WIDTH_WORD, 11'h000, x[20:5]);
					repeat (x[9:6]) @(posedge clock);
					dmaGo <= 1'b1;
				end else begin
					send(OP_WRITE, WIDTH_WORD, x[31:21], x[15:0]);
					send(OP_WRITE, width_t'(x[1:0]), x[31:21], x[20:5]);
					send(OP_READ, width_t'(x[3:2]), x[31:21], 16'h0000);
				end
			end
			drain();
			if (md == 0) begin
				stall <= 1'b1;
				for (int i = 0; i < 16; i++)
					send(OP_READ, WIDTH_WORD, 11'h000, 16'h0000);
				repeat (40) @(posedge clock);
				check("cmdReady", 17'h0_0000, {16'h0000, cmdReady});
				stall <= 1'b0;
				drain();
			end
		end
		finish_test();
	end
endmodule : card_host_bus_select_and_dma_test
